/* sbt_pkg.sv */
// Constants and types shared by the boundary-scan test access port
package sbt_pkg;

    // ==========================================================
    // Register sizes
    localparam int IR_LEN = 3;
    localparam int ID_LEN = 32;
    localparam int PIN_CELLS = 108;
    localparam int BSR_LEN = 109;
    localparam int OE_CELL = 108;

    // ==========================================================
    // Instruction codes
    localparam logic [2:0] IR_EXTEST = 3'h0;
    localparam logic [2:0] IR_IDCODE = 3'h1;
    localparam logic [2:0] IR_SAMPLEZ = 3'h2;
    localparam logic [2:0] IR_SAMPLE = 3'h4;
    localparam logic [2:0] IR_BYPASS = 3'h7;
    // Fixed pattern loaded into the instruction shifter at Capture-IR
    localparam logic [2:0] IR_CAPTURE = 3'h1;

    // ==========================================================
    // Identification register layout
    localparam int ID_REV_MSB = 31;
    localparam int ID_REV_LSB = 29;
    localparam int ID_PART_MSB = 28;
    localparam int ID_PART_LSB = 12;
    localparam int ID_MAKER_MSB = 11;
    localparam int ID_MAKER_LSB = 1;
    localparam int ID_PRESENT_BIT = 0;
    localparam logic ID_PRESENT = 1'h1;

    // ==========================================================
    // Reset values
    localparam logic [BSR_LEN-1:0] BSR_RESET = {1'h1, {PIN_CELLS{1'h0}}};

    // ==========================================================
    // Types
    typedef enum logic [3:0] {
        TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SHIFT_DR, TAP_EXIT1_DR,
        TAP_PAUSE_DR, TAP_EXIT2_DR, TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR, TAP_SHIFT_IR,
        TAP_EXIT1_IR, TAP_PAUSE_IR, TAP_EXIT2_IR, TAP_UPD_IR
    } sbt_tap_type;

    typedef enum logic [1:0] {
        SEL_BYPASS, SEL_ID, SEL_BSR
    } sbt_sel_type;

endpackage

/* sbt_boundary_scan_tap.sv */
// Boundary-scan test access port: test-clock controller and memory-clock pin muxing
`timescale 1ns/100ps
`default_nettype none

module sbt_boundary_scan_tap
    import sbt_pkg::*;
#(
    parameter logic [2:0] ID_REVISION = 3'h0,     // arbitrary value
    parameter logic [16:0] ID_PART = 17'h0A5A5,   // arbitrary value
    parameter logic [10:0] ID_MAKER = 11'h2A5     // arbitrary value
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    output logic tdo,
    output logic tdoOe,
    input wire logic [PIN_CELLS-1:0] pinIn,
    input wire logic [PIN_CELLS-1:0] coreOut,
    input wire logic coreQOe,
    output logic [PIN_CELLS-1:0] pinOut,
    output logic qOe
);

    // ==========================================================
    // Identification value
    localparam logic [ID_LEN-1:0] ID_VALUE = {ID_REVISION, ID_PART, ID_MAKER, ID_PRESENT};

    // ==========================================================
    // Helpers
    // Sixteen-state controller walk on TMS
    function automatic sbt_tap_type tapNext(input sbt_tap_type s, input logic m);
        sbt_tap_type r;
        r = s;
        unique case (s)
            TAP_RESET: r = m ? TAP_RESET : TAP_IDLE;
            TAP_IDLE: r = m ? TAP_SEL_DR : TAP_IDLE;
            TAP_SEL_DR: r = m ? TAP_SEL_IR : TAP_CAP_DR;
            TAP_CAP_DR: r = m ? TAP_EXIT1_DR : TAP_SHIFT_DR;
            TAP_SHIFT_DR: r = m ? TAP_EXIT1_DR : TAP_SHIFT_DR;
            TAP_EXIT1_DR: r = m ? TAP_UPD_DR : TAP_PAUSE_DR;
            TAP_PAUSE_DR: r = m ? TAP_EXIT2_DR : TAP_PAUSE_DR;
            TAP_EXIT2_DR: r = m ? TAP_UPD_DR : TAP_SHIFT_DR;
            TAP_UPD_DR: r = m ? TAP_SEL_DR : TAP_IDLE;
            TAP_SEL_IR: r = m ? TAP_RESET : TAP_CAP_IR;
            TAP_CAP_IR: r = m ? TAP_EXIT1_IR : TAP_SHIFT_IR;
            TAP_SHIFT_IR: r = m ? TAP_EXIT1_IR : TAP_SHIFT_IR;
            TAP_EXIT1_IR: r = m ? TAP_UPD_IR : TAP_PAUSE_IR;
            TAP_PAUSE_IR: r = m ? TAP_EXIT2_IR : TAP_PAUSE_IR;
            TAP_EXIT2_IR: r = m ? TAP_UPD_IR : TAP_SHIFT_IR;
            TAP_UPD_IR: r = m ? TAP_SEL_DR : TAP_IDLE;
        endcase
        return r;
    endfunction

    // Data register picked by an instruction; reserved codes fall to bypass
    function automatic sbt_sel_type dataSel(input logic [2:0] code);
        sbt_sel_type r;
        r = SEL_BYPASS;
        if (code == IR_IDCODE) begin
            r = SEL_ID;
        end else if (code == IR_EXTEST || code == IR_SAMPLEZ || code == IR_SAMPLE) begin
            r = SEL_BSR;
        end
        return r;
    endfunction

    // ==========================================================
    // Test-clock rising-edge state
    typedef struct packed {
        logic rst1;
        logic rst2;
        logic [PIN_CELLS-1:0] pin1;
        logic [PIN_CELLS-1:0] pin2;
        sbt_tap_type tap;
        logic [IR_LEN-1:0] irSh;
        logic [IR_LEN-1:0] cur;
        logic [ID_LEN-1:0] idSh;
        logic [BSR_LEN-1:0] bsrSh;
        logic [BSR_LEN-1:0] bsrUpd;
        logic byp;
        logic updTog;
    } sbt_tck_type;

    sbt_tck_type t_q;
    sbt_tck_type t_d;
    sbt_sel_type curSel;

    assign curSel = dataSel(t_q.cur);

    // Controller, shifters and update latches; all inputs sampled on the rising edge
    always_comb begin
        t_d = t_q;
        t_d.rst1 = ~reset_n;
        t_d.rst2 = t_q.rst1;
        // Pins are asynchronous to the test clock, so two stages before capture
        t_d.pin1 = pinIn;
        t_d.pin2 = t_q.pin1;
        t_d.tap = tapNext(t_q.tap, tms);
        if (t_q.rst2) begin
            t_d.tap = TAP_RESET;
            t_d.cur = IR_IDCODE;
            t_d.bsrUpd = BSR_RESET;
            t_d.irSh = IR_CAPTURE;
            t_d.idSh = ID_VALUE;
            t_d.bsrSh = BSR_RESET;
            t_d.byp = 1'h0;
            t_d.updTog = 1'h0;
        end else begin
            unique case (t_q.tap)
                TAP_RESET: begin
                    t_d.cur = IR_IDCODE;
                    t_d.bsrUpd[OE_CELL] = 1'h1;
                    // Toggle only on a real change: a toggle every test clock is
                    // shorter than a memory clock and could slip past the synchroniser
                    if (t_q.cur != IR_IDCODE || !t_q.bsrUpd[OE_CELL]) begin
                        t_d.updTog = ~t_q.updTog;
                    end
                end
                TAP_CAP_IR: t_d.irSh = IR_CAPTURE;
                TAP_SHIFT_IR: t_d.irSh = {tdi, t_q.irSh[IR_LEN-1:1]};
                TAP_UPD_IR: begin
                    t_d.cur = t_q.irSh;
                    t_d.updTog = ~t_q.updTog;
                end
                TAP_CAP_DR: begin
                    unique case (curSel)
                        SEL_ID: t_d.idSh = ID_VALUE;
                        SEL_BSR: t_d.bsrSh = {t_q.bsrUpd[OE_CELL], t_q.pin2};
                        SEL_BYPASS: t_d.byp = 1'h0;
                    endcase
                end
                TAP_SHIFT_DR: begin
                    unique case (curSel)
                        SEL_ID: t_d.idSh = {tdi, t_q.idSh[ID_LEN-1:1]};
                        SEL_BSR: t_d.bsrSh = {tdi, t_q.bsrSh[BSR_LEN-1:1]};
                        SEL_BYPASS: t_d.byp = tdi;
                    endcase
                end
                TAP_UPD_DR: begin
                    if (curSel == SEL_BSR) begin
                        t_d.bsrUpd = t_q.bsrSh;
                        t_d.updTog = ~t_q.updTog;
                    end
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge tck) begin
        t_q <= t_d;
    end

    // ==========================================================
    // Test-clock falling-edge output stage
    typedef struct packed {
        logic tdo;
        logic tdoOe;
    } sbt_neg_type;

    sbt_neg_type n_q;
    sbt_neg_type n_d;
    logic dataLsb;

    assign dataLsb = (curSel == SEL_ID) ? t_q.idSh[0] : (curSel == SEL_BSR) ? t_q.bsrSh[0] : t_q.byp;

    // Serial output moves only after a falling edge, half a period after the shift
    always_comb begin
        n_d = n_q;
        n_d.tdoOe = (t_q.tap == TAP_SHIFT_IR) || (t_q.tap == TAP_SHIFT_DR);
        if (t_q.rst2) begin
            n_d.tdo = 1'h0;
            n_d.tdoOe = 1'h0;
        end else if (t_q.tap == TAP_SHIFT_IR) begin
            n_d.tdo = t_q.irSh[0];
        end else if (t_q.tap == TAP_SHIFT_DR) begin
            n_d.tdo = dataLsb;
        end
    end

    always_ff @(negedge tck) begin
        n_q <= n_d;
    end

    assign tdo = n_q.tdo;
    assign tdoOe = n_q.tdoOe;

    // ==========================================================
    // Memory-clock pin muxing
    typedef struct packed {
        logic tog1;
        logic tog2;
        logic tog3;
        logic [IR_LEN-1:0] mode;
        logic [BSR_LEN-1:0] upd;
        logic [PIN_CELLS-1:0] pinOut;
        logic qOe;
    } sbt_clk_type;

    sbt_clk_type c_q;
    sbt_clk_type c_d;

    // Instruction and update cells are held still between updates, so a toggle
    // after two stages marks them safe to copy into this domain
    always_comb begin
        c_d = c_q;
        c_d.tog1 = t_q.updTog;
        c_d.tog2 = c_q.tog1;
        c_d.tog3 = c_q.tog2;
        if (c_q.tog2 != c_q.tog3) begin
            c_d.mode = t_q.cur;
            c_d.upd = t_q.bsrUpd;
        end
        c_d.pinOut = (c_q.mode == IR_EXTEST) ? c_q.upd[PIN_CELLS-1:0] : coreOut;
        if (c_q.mode == IR_SAMPLEZ) begin
            c_d.qOe = 1'h0;
        end else if (c_q.mode == IR_EXTEST) begin
            c_d.qOe = c_q.upd[OE_CELL];
        end else begin
            c_d.qOe = coreQOe;
        end
        if (!reset_n) begin
            c_d = '0;
            c_d.mode = IR_IDCODE;
            c_d.upd = BSR_RESET;
        end
    end

    always_ff @(posedge clk) begin
        c_q <= c_d;
    end

    assign pinOut = c_q.pinOut;
    assign qOe = c_q.qOe;

    // ==========================================================
    // Checks
    property p_ir_update;
        @(posedge tck) disable iff (t_q.rst2)
        t_q.tap == TAP_UPD_IR |=> t_q.cur == $past(t_q.irSh);
    endproperty
    a_ir_update: assert property (p_ir_update) else $error("instruction not taken at Update-IR");

    property p_reset_idcode;
        @(posedge tck) disable iff (t_q.rst2)
        t_q.tap == TAP_RESET |=> t_q.cur == IR_IDCODE && t_q.bsrUpd[OE_CELL];
    endproperty
    a_reset_idcode: assert property (p_reset_idcode) else $error("reset state lost id or oe cell");

    property p_oe_preset;
        @(posedge tck) disable iff (t_q.rst2)
        (tms && t_q.tap == TAP_SEL_IR) ##1 tms |=> t_q.bsrUpd[OE_CELL];
    endproperty
    a_oe_preset: assert property (p_oe_preset) else $error("output cell not preset");

    property p_id_capture;
        @(posedge tck) disable iff (t_q.rst2)
        t_q.tap == TAP_CAP_DR && t_q.cur == IR_IDCODE |=> t_q.idSh[0] == ID_PRESENT && t_q.idSh == ID_VALUE;
    endproperty
    a_id_capture: assert property (p_id_capture) else $error("identification capture wrong");

    property p_bsr_capture;
        @(posedge tck) disable iff (t_q.rst2)
        t_q.tap == TAP_CAP_DR && t_q.cur == IR_SAMPLE |=> t_q.bsrSh[PIN_CELLS-1:0] == $past(t_q.pin2);
    endproperty
    a_bsr_capture: assert property (p_bsr_capture) else $error("pin capture wrong");

    property p_bsr_shift;
        @(posedge tck) disable iff (t_q.rst2)
        t_q.tap == TAP_SHIFT_DR && curSel == SEL_BSR |=> t_q.bsrSh[BSR_LEN-1] == $past(tdi);
    endproperty
    a_bsr_shift: assert property (p_bsr_shift) else $error("serial input not at top cell");

    property p_bypass;
        @(posedge tck) disable iff (t_q.rst2)
        t_q.tap == TAP_SHIFT_DR && t_q.cur == IR_BYPASS ##1 t_q.tap == TAP_SHIFT_DR |-> n_d.tdo == $past(tdi);
    endproperty
    a_bypass: assert property (p_bypass) else $error("bypass is not one stage");

    property p_tdo_fall;
        @(negedge tck) disable iff (t_q.rst2)
        t_q.tap == TAP_SHIFT_IR |=> tdo == $past(t_q.irSh[0]) && tdoOe;
    endproperty
    a_tdo_fall: assert property (p_tdo_fall) else $error("serial output wrong after fall");

    property p_samplez_float;
        @(posedge clk) disable iff (!reset_n)
        c_q.mode == IR_SAMPLEZ |=> !qOe;
    endproperty
    a_samplez_float: assert property (p_samplez_float) else $error("outputs drive in float mode");

    property p_extest_drive;
        @(posedge clk) disable iff (!reset_n)
        c_q.mode == IR_EXTEST |=> pinOut == $past(c_q.upd[PIN_CELLS-1:0]) && qOe == $past(c_q.upd[OE_CELL]);
    endproperty
    a_extest_drive: assert property (p_extest_drive) else $error("preload not driven");

endmodule

`default_nettype wire

/* sbt_jtag_host.sv */
// Test controller model that drives the serial test port
`timescale 1ns/100ps
`default_nettype none

module sbt_jtag_host (
    output logic tck,
    output logic tms,
    output logic tdi,
    input wire logic tdo
);
    // ==========================================================
    // Idle levels; the test clock stands still between frames
    initial begin
        tck = 1'h0;
        tms = 1'h1;
        tdi = 1'h0;
    end

    // ==========================================================
    // One 48 ns cycle: move inputs while low, read output before the rise
    task automatic step(input logic t, input logic d, output logic o);
        tms = t;
        tdi = d;
        #24;
        o = tdo;
        tck = 1'h1;
        #24;
        tck = 1'h0;
    endtask

    // Five ones reach Test-Logic-Reset from any state, then park in idle
    task automatic tlr();
        logic o;
        repeat (5) step(1'b1, 1'b0, o);
        step(1'b0, 1'b0, o);
    endtask

    // Idle to idle scan of n bits, LSB first, through capture and update
    task automatic scan(input logic ir, input int n, input logic [127:0] din, output logic [127:0] dout);
        logic o;
        dout = '0;
        step(1'b1, 1'b0, o);
        if (ir) step(1'b1, 1'b0, o);
        step(1'b0, 1'b0, o);
        step(1'b0, 1'b0, o);
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, din[i], o);
            dout[i] = o;
        end
        step(1'b1, 1'b0, o);
        step(1'b0, 1'b0, o);
    endtask
endmodule

`default_nettype wire

/* tb_top.sv */
// Self-checking bench for the boundary-scan test access port
`timescale 1ns/100ps
`default_nettype none

module tb_top;
    import sbt_pkg::*;

    // ==========================================================
    // Identity values and pin patterns
    localparam logic [2:0] REV = 3'h5; // arbitrary value
    localparam logic [16:0] PART = 17'h1B2C3; // arbitrary value
    localparam logic [10:0] MAKER = 11'h3C5; // arbitrary value
    localparam logic [31:0] ID_EXP = {REV, PART, MAKER, ID_PRESENT};
    localparam logic [107:0] PAT_A = {9{12'hA5C}};
    localparam logic [107:0] PAT_B = {9{12'h3C6}};
    localparam logic [107:0] PAT_C = {9{12'h96E}};
    localparam logic [107:0] PAT_D = {9{12'h5F1}};

    typedef struct packed {logic [2:0] code; logic [1:0] kind; logic qe;} sbt_row_type;
    // Kind 0 bypass, 1 identification, 2 boundary register
    // Reserved codes are never loaded; the port would select bypass for them, as for code 7
    sbt_row_type rows [7] = '{'{3'h7, 2'h0, 1'h0}, '{3'h7, 2'h0, 1'h1}, '{3'h1, 2'h1, 1'h1},
        '{3'h4, 2'h2, 1'h0}, '{3'h1, 2'h1, 1'h0}, '{3'h4, 2'h2, 1'h1}, '{3'h2, 2'h2, 1'h1}};

    logic clk, reset_n, tck, tms, tdi, tdo, tdoOe, tdoWire, coreQOe, qOe;
    logic [107:0] pinIn, coreOut, pinOut;
    int err_count = 0;
    int check_count = 0;

    // Released line shows the inverse so a stale value cannot pass
    assign tdoWire = tdoOe ? tdo : ~tdo;

    sbt_jtag_host host (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdoWire));

    sbt_boundary_scan_tap #(.ID_REVISION(REV), .ID_PART(PART), .ID_MAKER(MAKER)) uut (
        .clk(clk), .reset_n(reset_n), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdoOe(tdoOe),
        .pinIn(pinIn), .coreOut(coreOut), .coreQOe(coreQOe), .pinOut(pinOut), .qOe(qOe));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // ==========================================================
    // Comparison and verdict
    task automatic check(input logic [127:0] seen, input logic [127:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic test_done();
        if (err_count == 0 && check_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    // Pin side needs a few memory clocks to see a test-side update
    task automatic load_ir(input logic [2:0] code);
        logic [127:0] o;
        host.scan(1'b1, IR_LEN, {125'h0, code}, o);
        check(o[2:0], IR_CAPTURE);
        repeat (8) @(posedge clk);
    endtask

    // Output may move only once the test clock is low
    always @(tdo) if (reset_n === 1'b1) check(tck, 1'b0);

    initial begin
        repeat (20000) @(posedge clk);
        err_count++;
        test_done();
    end

    // ==========================================================
    // Main sequence
    initial begin
        logic [127:0] o;
        logic [127:0] d;
        reset_n = 1'b0;
        coreOut = '0;
        coreQOe = 1'b0;
        pinIn = '0;
        repeat (4) @(posedge clk);
        host.tlr();
        check(pinOut, '0);
        check(qOe, 1'h0);
        @(posedge clk);
        reset_n <= 1'b1;
        coreOut <= PAT_A;
        coreQOe <= 1'b1;
        pinIn <= PAT_B;
        @(posedge clk);
        host.tlr();
        repeat (8) @(posedge clk);
        check(pinOut, PAT_A);
        host.scan(1'b0, ID_LEN, '0, o);
        check(o[31:0], ID_EXP);
        d = {19'h0, 1'b1, PAT_C};
        foreach (rows[i]) begin
            @(posedge clk);
            coreQOe <= rows[i].qe;
            load_ir(rows[i].code);
            check(qOe, rows[i].code == IR_SAMPLEZ ? 1'b0 : rows[i].qe);
            host.scan(1'b0, rows[i].kind == 2'h2 ? BSR_LEN : (rows[i].kind == 2'h1 ? ID_LEN : 40), d, o);
            if (rows[i].kind == 2'h0) check(o[39:0], {d[38:0], 1'b0});
            else if (rows[i].kind == 2'h1) check(o[31:0], ID_EXP);
            else check(o[108:0], {1'b1, PAT_B});
            repeat (8) @(posedge clk);
            check(pinOut, PAT_A);
        end
        // Preloaded cells drive the pins, cell 108 the read outputs
        load_ir(IR_EXTEST);
        check(pinOut, PAT_C);
        check(qOe, 1'b1);
        host.scan(1'b0, BSR_LEN, {19'h0, 1'b0, PAT_D}, o);
        check(o[108:0], {1'b1, PAT_B});
        repeat (8) @(posedge clk);
        check(pinOut, PAT_D);
        check(qOe, 1'b0);
        // Test-Logic-Reset restores identification and presets cell 108
        host.tlr();
        repeat (8) @(posedge clk);
        check(pinOut, PAT_A);
        host.scan(1'b0, ID_LEN, '0, o);
        check(o[31:0], ID_EXP);
        load_ir(IR_EXTEST);
        check(qOe, 1'b1);
        test_done();
    end
endmodule

`default_nettype wire
